//--- soim_consts.svh
`ifndef SOIM_CONSTS_SVH
`define SOIM_CONSTS_SVH

// Clock and base tick
`define SOIM_CLK_HZ        100_000_000
`define SOIM_TICK_US       1000
`define SOIM_TICK_CYC      ((`SOIM_CLK_HZ / 1_000_000) * `SOIM_TICK_US)

// Times in milliseconds, counted in base ticks
`define SOIM_EDM_MS        300
`define SOIM_LAMP_HZ       1
`define SOIM_LAMP_HALF_MS  (1000 / (2 * `SOIM_LAMP_HZ))
`define SOIM_DISC_MS       100
`define SOIM_CNT_W         10

// Register byte addresses
`define SOIM_ADDR_W        12
`define SOIM_ADDR_CTRL     12'h000
`define SOIM_ADDR_STAT     12'h004

// Control reset value: restart interlock on, all else off
`define SOIM_CTRL_RST      6'h01

`endif

//--- soim_field.sv
`timescale 1ns/1ns
`default_nettype none

module soim_field #(
  parameter int DLY = 20
) (
  // Clock
  input  wire logic pclk,
  // Safety outputs from the device
  input  wire logic safety_output_a,
  input  wire logic safety_output_b,
  // Fault and wiring controls
  input  wire logic estop_pressed,
  input  wire logic wired_compl,
  input  wire logic stuck,
  input  wire logic stuck_val,
  // Field signals back to the device
  output logic      contactor_feedback,
  output logic      estop_ch1,
  output logic      estop_ch2
);
  int   cnt = 0;
  logic energised = 1'b0;

  // Contactors follow the outputs only after a mechanical delay
  always @(posedge pclk) begin
    if ((safety_output_a & safety_output_b) == energised) begin
      cnt <= 0;
    end else if (cnt == DLY) begin
      energised <= ~energised;
      cnt       <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end

  assign contactor_feedback = stuck ? stuck_val : ~energised;
  assign estop_ch1 = ~estop_pressed;
  assign estop_ch2 = wired_compl ? estop_pressed : ~estop_pressed;
endmodule

`default_nettype wire

//--- soim_monitor.sv
`include "soim_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module soim_monitor
  import soim_pkg::*;
#(
  parameter int TICK_CYC = `SOIM_TICK_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins from the field
  input  wire logic        field_clear,
  input  wire logic        reset_button,
  input  wire logic        contactor_feedback,
  input  wire logic        estop_ch1,
  input  wire logic        estop_ch2,
  input  wire logic        sender_test_n,
  // Pins to the field
  output logic             safety_output_a,
  output logic             safety_output_b,
  output logic             reset_required_lamp,
  output logic             auxiliary_signal_output,
  output logic             sender_test_active,
  output logic             error_indication
);

  soim_pins_t  pins_raw;
  soim_pins_t  pin;
  logic        tick;
  logic        btn_d_r;
  logic        press;

  soim_ctrl_t  ctrl_r, ctrl_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;

  soim_state_t state_r, state_nxt;
  logic [`SOIM_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [`SOIM_CNT_W-1:0] lamp_cnt_r, lamp_cnt_nxt;
  logic [`SOIM_CNT_W-1:0] disc_r, disc_nxt;
  logic        lamp_ph_r, lamp_ph_nxt;
  logic        edm_fault_r, edm_fault_nxt;
  logic        wiring_err_r, wiring_err_nxt;

  logic        estop_off;
  logic        mismatch;
  logic        trip;
  logic        edm_block;
  logic        disc_done;
  logic        edm_done;

  logic        out_on_r, out_on_nxt;
  logic        lamp_r, lamp_nxt;
  logic        ado_r, ado_nxt;
  logic        test_r, test_nxt;
  logic        err_r, err_nxt;

  assign pins_raw = '{test_n: sender_test_n, estop2: estop_ch2, estop1: estop_ch1,
                      feedback: contactor_feedback, reset_btn: reset_button,
                      field_clear: field_clear};

  soim_sync #(.W($bits(soim_pins_t))) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pins_raw),
    .q       (pin)
  );

  soim_tick #(.CYC(TICK_CYC)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // Register interface
  always_comb begin
    ctrl_nxt    = ctrl_r;
    pready_nxt  = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt  = '0;
    if (psel && !penable) begin
      case (paddr)
        `SOIM_ADDR_CTRL: prdata_nxt = pwrite ? '0 : 32'(ctrl_r);
        `SOIM_ADDR_STAT: prdata_nxt = pwrite ? '0 : 32'(stat_word());
        default:         pslverr_nxt = 1'b1;
      endcase
    end
    if (psel && penable && pready_r && pwrite && paddr == `SOIM_ADDR_CTRL) begin
      ctrl_nxt = soim_ctrl_t'(pwdata[$bits(soim_ctrl_t)-1:0]);
    end
  end

  function automatic soim_stat_t stat_word();
    soim_stat_t s;
    s.reset_req   = (state_r == ST_WAIT);
    s.field_clear = pin.field_clear;
    s.test_active = test_r;
    s.lockout     = (state_r == ST_LOCK);
    s.wiring_err  = wiring_err_r;
    s.edm_fault   = edm_fault_r;
    s.state       = state_r;
    return s;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r    <= `SOIM_CTRL_RST;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // Input interpretation
  always_comb begin
    press     = pin.reset_btn && !btn_d_r;
    mismatch  = ctrl_r.estop_en &&
                (ctrl_r.estop_compl ? (pin.estop1 == pin.estop2)
                                    : (pin.estop1 != pin.estop2));
    estop_off = ctrl_r.estop_en &&
                (ctrl_r.estop_compl ? (!pin.estop1 || pin.estop2)
                                    : (!pin.estop1 || !pin.estop2));
    trip      = !pin.field_clear || estop_off;
    edm_block = ctrl_r.edm_en && !pin.feedback;
    disc_done = tick && disc_r == `SOIM_CNT_W'(`SOIM_DISC_MS - 1);
    edm_done  = tick && cnt_r == `SOIM_CNT_W'(`SOIM_EDM_MS - 1);
  end

  // Supervision state machine
  always_comb begin
    state_nxt      = state_r;
    cnt_nxt        = (tick && state_r == ST_CHECK) ? cnt_r + 1'b1 : cnt_r;
    disc_nxt       = !mismatch ? '0 : (tick ? disc_r + 1'b1 : disc_r);
    edm_fault_nxt  = edm_fault_r;
    wiring_err_nxt = !ctrl_r.edm_en && pin.feedback;
    case (state_r)
      ST_OFF: begin
        if (edm_block) begin
          edm_fault_nxt = 1'b1;
        end else if (!trip) begin
          state_nxt = ctrl_r.restart_en ? ST_WAIT : ST_CHECK;
        end
      end
      ST_WAIT: begin
        if (trip || edm_block) begin
          state_nxt = ST_OFF;
        end else if (press) begin
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (trip) begin
          state_nxt = ST_OFF;
        end else if (!ctrl_r.edm_en || !pin.feedback) begin
          state_nxt     = ST_ON;
          edm_fault_nxt = 1'b0;
        end else if (edm_done) begin
          state_nxt     = ST_OFF;
          edm_fault_nxt = 1'b1;
        end
      end
      ST_ON: begin
        if (trip) begin
          state_nxt = ST_OFF;
        end
      end
      ST_LOCK: state_nxt = ST_LOCK;
      default: state_nxt = ST_LOCK;
    endcase
    if (disc_done) begin
      state_nxt = ST_LOCK;
    end
    if (state_nxt != state_r) begin
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= ST_OFF;
      cnt_r        <= '0;
      disc_r       <= '0;
      edm_fault_r  <= 1'b0;
      wiring_err_r <= 1'b0;
      btn_d_r      <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      disc_r       <= disc_nxt;
      edm_fault_r  <= edm_fault_nxt;
      wiring_err_r <= wiring_err_nxt;
      btn_d_r      <= pin.reset_btn;
    end
  end

  // Output drivers
  always_comb begin
    lamp_cnt_nxt = lamp_cnt_r;
    lamp_ph_nxt  = lamp_ph_r;
    if (state_r != ST_WAIT) begin
      lamp_cnt_nxt = '0;
      lamp_ph_nxt  = 1'b1;
    end else if (tick) begin
      // half period of the lamp blink
      if (lamp_cnt_r == `SOIM_CNT_W'(`SOIM_LAMP_HALF_MS - 1)) begin
        lamp_cnt_nxt = '0;
        lamp_ph_nxt  = !lamp_ph_r;
      end else begin
        lamp_cnt_nxt = lamp_cnt_r + 1'b1;
      end
    end
    out_on_nxt = (state_nxt == ST_CHECK) || (state_nxt == ST_ON);
    lamp_nxt   = (state_nxt == ST_WAIT) && lamp_ph_nxt;
    ado_nxt    = ctrl_r.ado_en && out_on_nxt;
    // low input runs test when enabled
    test_nxt   = ctrl_r.test_en && !pin.test_n;
    err_nxt    = wiring_err_nxt || edm_fault_nxt || (state_nxt == ST_LOCK);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamp_cnt_r <= '0;
      lamp_ph_r  <= 1'b1;
      out_on_r   <= 1'b0;
      lamp_r     <= 1'b0;
      ado_r      <= 1'b0;
      test_r     <= 1'b0;
      err_r      <= 1'b0;
    end else begin
      lamp_cnt_r <= lamp_cnt_nxt;
      lamp_ph_r  <= lamp_ph_nxt;
      out_on_r   <= out_on_nxt;
      lamp_r     <= lamp_nxt;
      ado_r      <= ado_nxt;
      test_r     <= test_nxt;
      err_r      <= err_nxt;
    end
  end

  assign prdata                  = prdata_r;
  assign pready                  = pready_r;
  assign pslverr                 = pslverr_r;
  assign safety_output_a         = out_on_r;
  assign safety_output_b         = out_on_r;
  assign reset_required_lamp     = lamp_r;
  assign auxiliary_signal_output = ado_r;
  assign sender_test_active      = test_r;
  assign error_indication        = err_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  edm_timeout_a: assert property (
    state_r == ST_CHECK && !trip && ctrl_r.edm_en && pin.feedback && edm_done && !disc_done
    |=> state_r == ST_OFF && edm_fault_r && !safety_output_a)
    else $error("outputs not dropped after feedback timeout");
  edm_block_a: assert property (
    state_r == ST_OFF && edm_block && !disc_done
    |=> state_r == ST_OFF && edm_fault_r && !safety_output_a)
    else $error("restart not blocked on missing feedback");
  wiring_err_a: assert property (
    !ctrl_r.edm_en && pin.feedback |=> error_indication)
    else $error("feedback wiring error not shown");
  reset_needed_a: assert property (
    state_r == ST_WAIT && !press |=> !safety_output_a && !safety_output_b)
    else $error("outputs came on without reset press");
  lamp_blink_a: assert property (
    state_r == ST_WAIT && state_nxt == ST_WAIT && tick &&
    lamp_cnt_r == `SOIM_CNT_W'(`SOIM_LAMP_HALF_MS - 1)
    |=> lamp_ph_r != $past(lamp_ph_r) ##0 reset_required_lamp == lamp_ph_r)
    else $error("reset lamp did not toggle at half period");
  estop_trip_a: assert property (
    state_r == ST_ON && estop_off |=> !safety_output_a && state_r != ST_ON)
    else $error("emergency stop did not drop outputs");
  lockout_hold_a: assert property (
    disc_done |=> state_r == ST_LOCK [*3] ##0 !safety_output_a)
    else $error("wiring mismatch did not lock out");
  test_run_a: assert property (
    ctrl_r.test_en && !pin.test_n |=> sender_test_active)
    else $error("sender test not active on low input");
  test_gate_a: assert property (
    !ctrl_r.test_en |=> !sender_test_active)
    else $error("sender test active while disabled");
  outputs_pair_a: assert property (
    trip || state_r == ST_LOCK |=> !safety_output_a && !safety_output_b)
    else $error("safety outputs not both off on trip");
  restart_c: cover property (state_r == ST_WAIT && press ##1 state_r == ST_CHECK);
  edm_fail_c: cover property (state_r == ST_CHECK ##1 state_r == ST_OFF && edm_fault_r);
  lock_c: cover property (state_r == ST_OFF ##1 state_r == ST_LOCK);
  estop_c: cover property (state_r == ST_ON && estop_off ##1 state_r == ST_OFF);

endmodule

`default_nettype wire

//--- soim_pkg.sv
package soim_pkg;

  typedef enum logic [4:0] {
    ST_OFF   = 5'h01,
    ST_WAIT  = 5'h02,
    ST_CHECK = 5'h04,
    ST_ON    = 5'h08,
    ST_LOCK  = 5'h10
  } soim_state_t;

  typedef struct packed {
    logic ado_en;
    logic test_en;
    logic estop_compl;
    logic estop_en;
    logic edm_en;
    logic restart_en;
  } soim_ctrl_t;

  typedef struct packed {
    logic test_n;
    logic estop2;
    logic estop1;
    logic feedback;
    logic reset_btn;
    logic field_clear;
  } soim_pins_t;

  typedef struct packed {
    logic        reset_req;
    logic        field_clear;
    logic        test_active;
    logic        lockout;
    logic        wiring_err;
    logic        edm_fault;
    soim_state_t state;
  } soim_stat_t;

endpackage

//--- soim_sync.sv
`timescale 1ns/1ns
`default_nettype none

module soim_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;

endmodule

`default_nettype wire

//--- soim_tick.sv
`timescale 1ns/1ns
`default_nettype none

module soim_tick #(
  parameter int CYC = 1000
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Base tick
  output logic      tick
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;

  always_comb begin
    tick_nxt = (cnt_r == 32'(CYC - 1));
    cnt_nxt  = tick_nxt ? '0 : cnt_r + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule

`default_nettype wire

//--- tb.sv
`timescale 1ns/1ns
`default_nettype none

module tb;
  import soim_pkg::*;
  localparam int TCK = 10;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic field_clear, reset_button, fb, e1, e2, sender_test_n;
  logic out_a, out_b, lamp, aux, test_act, err_ind;
  logic estop_pressed, wired_compl, stuck, stuck_val;
  int   mismatches = 0;
  int   n_compared = 0;
  int   cycles = 0;

  soim_monitor #(.TICK_CYC(TCK)) i_soim_monitor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .field_clear(field_clear), .reset_button(reset_button), .contactor_feedback(fb),
    .estop_ch1(e1), .estop_ch2(e2), .sender_test_n(sender_test_n),
    .safety_output_a(out_a), .safety_output_b(out_b), .reset_required_lamp(lamp),
    .auxiliary_signal_output(aux), .sender_test_active(test_act),
    .error_indication(err_ind));

  soim_field i_soim_field (
    .pclk(pclk), .safety_output_a(out_a), .safety_output_b(out_b),
    .estop_pressed(estop_pressed), .wired_compl(wired_compl), .stuck(stuck),
    .stuck_val(stuck_val), .contactor_feedback(fb), .estop_ch1(e1), .estop_ch2(e2));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] outs();
    return {30'h0000_0000, out_a, out_b};
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the slave's pready; no local limit, only the bench timeout ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input logic [31:0] ctrl);
    @(posedge pclk);
    presetn     <= 1'b0;
    field_clear <= 1'b0;
    stuck       <= 1'b0;
    cyc(6);
    presetn <= 1'b1;
    apb(1'b1, 12'h000, ctrl);
  endtask

  task automatic wait_out(input logic v);
    int n;
    n = 0;
    while (out_a !== v && n < 50) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // operator press, held past the synchronisers
  task automatic press();
    reset_button <= 1'b1;
    cyc(5);
    reset_button <= 1'b0;
    cyc(2);
  endtask

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0000_0000; field_clear = 1'b0;
    reset_button = 1'b0; sender_test_n = 1'b1; estop_pressed = 1'b0;
    wired_compl = 1'b0; stuck = 1'b0; stuck_val = 1'b0;
    cyc(6);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk({27'h000_0000, rd[4:0]}, 32'h0000_0001);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    // Restart interlock and lamp
    field_clear <= 1'b1;
    cyc(10);
    chk(outs(), 32'h0000_0000);
    chk({31'h0000_0000, err_ind}, 32'h0000_0001);
    cyc(2500);
    chk({31'h0000_0000, lamp}, 32'h0000_0001);
    cyc(5000);
    chk({31'h0000_0000, lamp}, 32'h0000_0000);
    press();
    wait_out(1'b1);
    chk(outs(), 32'h0000_0003);
    // Emergency stop behaves like a field interruption
    apb(1'b1, 12'h000, 32'h0000_0025);
    cyc(5);
    chk({31'h0000_0000, aux}, 32'h0000_0001);
    estop_pressed <= 1'b1;
    wait_out(1'b0);
    chk(outs(), 32'h0000_0000);
    estop_pressed <= 1'b0;
    cyc(20);
    chk(outs(), 32'h0000_0000);
    press();
    wait_out(1'b1);
    chk(outs(), 32'h0000_0003);
    field_clear <= 1'b0;
    wait_out(1'b0);
    chk(outs(), 32'h0000_0000);
    // Healthy contactors with feedback monitoring
    do_reset(32'h0000_0003);
    field_clear <= 1'b1;
    cyc(20);
    press();
    cyc(3200);
    chk(outs(), 32'h0000_0003);
    chk({31'h0000_0000, err_ind}, 32'h0000_0000);
    // Contactor never pulls in
    do_reset(32'h0000_0003);
    stuck <= 1'b1;
    stuck_val <= 1'b1;
    field_clear <= 1'b1;
    cyc(20);
    press();
    wait_out(1'b1);
    cyc(2800);
    chk(outs(), 32'h0000_0003);
    cyc(250);
    chk(outs(), 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk({31'h0000_0000, rd[5]}, 32'h0000_0001);
    // Feedback missing while released
    do_reset(32'h0000_0003);
    stuck <= 1'b1;
    stuck_val <= 1'b0;
    field_clear <= 1'b1;
    cyc(20);
    chk({31'h0000_0000, err_ind}, 32'h0000_0001);
    press();
    cyc(20);
    chk(outs(), 32'h0000_0000);
    // Emergency stop wiring mismatch
    do_reset(32'h0000_0005);
    wired_compl <= 1'b1;
    field_clear <= 1'b1;
    cyc(1200);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk({31'h0000_0000, rd[7]}, 32'h0000_0001);
    press();
    cyc(20);
    chk(outs(), 32'h0000_0000);
    wired_compl <= 1'b0;
    // Sender test gating
    do_reset(32'h0000_0001);
    sender_test_n <= 1'b0;
    cyc(6);
    chk({31'h0000_0000, test_act}, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0011);
    cyc(6);
    chk({31'h0000_0000, test_act}, 32'h0000_0001);
    sender_test_n <= 1'b1;
    cyc(6);
    chk({31'h0000_0000, test_act}, 32'h0000_0000);
    report_and_stop();
  end
endmodule

`default_nettype wire
